// File: src/port_controller_id_register_map.sv
// register map of a type-c port controller, reached as an i2c target by byte address
// assumes one device clock, power-on reset, and an i2c controller on the far side
//
// Behaviour
// (RULE1) vendor code: two fixed bytes, low first
// (RULE2) product code low marks variant, high fixed
// (RULE3) release code: two fixed bytes, low first
// (RULE4) connector revision always reads 1.3 bcd
// (RULE5) delivery version always reads 1.2 bcd
// (RULE6) delivery revision always reads 3.0 bcd
// (RULE7) voltage high byte: scale above reading top
// (RULE8) converter setup packs slope, frequency, sync, spread
// (RULE9) interface version always reads 1.1 bcd
// (RULE10) interface revision always reads 2.0 bcd
// (RULE11) identification writes acknowledged, values unchanged
`timescale 1ns/1ps
`default_nettype none
module port_controller_id_register_map
   import port_map_pkg::*;
#(
   parameter logic [6:0] DEVICE_ADDRESS = 7'h22,
   // arbitrary identification values
   parameter logic [15:0] VENDOR_CODE = 16'h3c7e,
   parameter logic [7:0] PRODUCT_LOW_BUCK_BOOST = 8'h51,
   parameter logic [7:0] PRODUCT_LOW_BUCK_ONLY = 8'h52,
   parameter logic [7:0] PRODUCT_HIGH = 8'h5a,
   parameter logic [15:0] RELEASE_CODE = 16'h0a17,
   parameter logic [47:0] CAPABILITIES = 48'h1234_5678_9abc
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // i2c pins, open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // variant strap pin
   input wire logic buck_boost_strap,
   // live state from the power stage
   input wire status_in_t status_in,
   input wire logic [W1C_COUNT*8-1:0] event_set,
   // controls and strobes to the power stage
   output control_out_t control_out,
   output write_pulse_t write_pulse,
   output logic alert_n
);

   // refuse a build where the two variants cannot be told apart
   if (PRODUCT_LOW_BUCK_BOOST == PRODUCT_LOW_BUCK_ONLY) begin : g_product_check
      $error("product codes of the two variants must differ");
   end

   typedef enum logic [3:0] {
      IDLE, ADDR, ADDR_ACK, REG, REG_ACK, WRITE, WRITE_ACK, READ, READ_ACK
   } bus_state_t;

   bus_state_t state_q;
   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;
   logic read_dir_q;
   logic [7:0] ptr_q;
   logic sda_oe_q;
   logic sda_out_q;
   logic [1:0] strap_sync_q;
   logic [1:0] strap_wait_q;
   logic strap_q;
   logic [7:0] rw_q [RW_COUNT];
   logic [7:0] w1c_q [W1C_COUNT];
   logic alert_n_q;
   write_pulse_t pulse_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic sda_level;
   logic wr_fire;
   logic [7:0] rd_byte;

   // ----------------------------------------
   // pin conditioning
   // ----------------------------------------
   i2c_line_watch u_watch (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_seen(start_seen),
      .stop_seen(stop_seen),
      .sda_level(sda_level)
   );

   // ----------------------------------------
   // variant strap, caught after reset release
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         strap_sync_q <= 2'h0;
         strap_wait_q <= 2'h0;
         strap_q <= 1'b0;
      end else begin
         strap_sync_q <= {strap_sync_q[0], buck_boost_strap};
         if (strap_wait_q != 2'h3) begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q == 2'h2) begin
               strap_q <= strap_sync_q[1];
            end
         end
      end
   end

   // ----------------------------------------
   // read decode
   // ----------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      unique case (ptr_q)
         VENDOR_CODE_LOW: rd_byte = VENDOR_CODE[7:0]; // RULE1
         VENDOR_CODE_HIGH: rd_byte = VENDOR_CODE[15:8]; // RULE1
         PRODUCT_CODE_LOW: rd_byte = strap_q ? PRODUCT_LOW_BUCK_BOOST : PRODUCT_LOW_BUCK_ONLY; // RULE2
         PRODUCT_CODE_HIGH: rd_byte = PRODUCT_HIGH; // RULE2
         RELEASE_CODE_LOW: rd_byte = RELEASE_CODE[7:0]; // RULE3
         RELEASE_CODE_HIGH: rd_byte = RELEASE_CODE[15:8]; // RULE3
         CONNECTOR_SPEC_REV: rd_byte = CONNECTOR_SPEC_REV_VAL; // RULE4
         DELIVERY_SPEC_VERSION: rd_byte = DELIVERY_SPEC_VERSION_VAL; // RULE5
         DELIVERY_SPEC_REVISION: rd_byte = DELIVERY_SPEC_REVISION_VAL; // RULE6
         INTERFACE_SPEC_VERSION: rd_byte = INTERFACE_SPEC_VERSION_VAL; // RULE9
         INTERFACE_SPEC_REVISION: rd_byte = INTERFACE_SPEC_REVISION_VAL; // RULE10
         CONFIG_LINE_STATE: rd_byte = status_in.config_line_state;
         POWER_STATE: rd_byte = status_in.power_state;
         EXTENDED_STATE: rd_byte = status_in.extended_state & 8'h01;
         BUS_VOLTAGE_LOW: rd_byte = status_in.bus_voltage_reading[7:0]; // RULE7
         BUS_VOLTAGE_HIGH: begin
            rd_byte = 8'h00;
            rd_byte[READING_SCALE_POS +: 2] = status_in.reading_scale; // RULE7
            rd_byte[READING_TOP_POS +: 2] = status_in.bus_voltage_reading[9:8]; // RULE7
         end
         default: begin
            if (ptr_q >= CAPABILITY_FIRST && ptr_q <= CAPABILITY_LAST) begin
               rd_byte = CAPABILITIES[8*(ptr_q - CAPABILITY_FIRST) +: 8];
            end
            for (int i = 0; i < RW_COUNT; i++) begin
               if (ptr_q == RW_OFFSET[i]) begin
                  rd_byte = rw_q[i];
               end
            end
            for (int i = 0; i < W1C_COUNT; i++) begin
               if (ptr_q == W1C_OFFSET[i]) begin
                  rd_byte = w1c_q[i] & W1C_LIVE[i];
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // i2c target sequencing
   // ----------------------------------------
   assign wr_fire = (state_q == WRITE) && scl_fall && (bit_cnt_q == 4'h8);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= IDLE;
         shift_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         read_dir_q <= 1'b0;
         ptr_q <= 8'h00;
         sda_oe_q <= 1'b0;
      end else if (start_seen) begin
         state_q <= ADDR;
         bit_cnt_q <= 4'h0;
         sda_oe_q <= 1'b0;
      end else if (stop_seen) begin
         state_q <= IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            IDLE: begin
               sda_oe_q <= 1'b0;
            end
            ADDR, REG, WRITE: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_level};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == 4'h8) begin
                  bit_cnt_q <= 4'h0;
                  sda_oe_q <= 1'b1;
                  if (state_q == ADDR) begin
                     if (shift_q[7:1] == DEVICE_ADDRESS) begin
                        read_dir_q <= shift_q[0];
                        state_q <= ADDR_ACK;
                     end else begin
                        sda_oe_q <= 1'b0;
                        state_q <= IDLE;
                     end
                  end else if (state_q == REG) begin
                     ptr_q <= shift_q;
                     state_q <= REG_ACK;
                  end else begin
                     // every byte is acknowledged, fixed registers included
                     ptr_q <= ptr_q + 8'h01; // RULE11
                     state_q <= WRITE_ACK;
                  end
               end
            end
            ADDR_ACK: begin
               if (scl_fall) begin
                  if (read_dir_q) begin
                     shift_q <= {rd_byte[6:0], 1'b0};
                     sda_oe_q <= !rd_byte[7];
                     bit_cnt_q <= 4'h1;
                     state_q <= READ;
                  end else begin
                     sda_oe_q <= 1'b0;
                     state_q <= REG;
                  end
               end
            end
            REG_ACK, WRITE_ACK: begin
               if (scl_fall) begin
                  sda_oe_q <= 1'b0;
                  state_q <= WRITE;
               end
            end
            READ: begin
               if (scl_fall) begin
                  if (bit_cnt_q == 4'h8) begin
                     sda_oe_q <= 1'b0;
                     state_q <= READ_ACK;
                  end else begin
                     sda_oe_q <= !shift_q[7];
                     shift_q <= {shift_q[6:0], 1'b0};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            READ_ACK: begin
               if (scl_rise) begin
                  ptr_q <= ptr_q + 8'h01;
                  if (sda_level) begin
                     state_q <= IDLE;
                  end
               end else if (scl_fall) begin
                  // pointer has already moved to the next byte
                  shift_q <= {rd_byte[6:0], 1'b0};
                  sda_oe_q <= !rd_byte[7];
                  bit_cnt_q <= 4'h1;
                  state_q <= READ;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // read-write registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < RW_COUNT; i++) begin
            rw_q[i] <= RW_RESET[i];
         end
      end else if (wr_fire) begin
         for (int i = 0; i < RW_COUNT; i++) begin
            if (ptr_q == RW_OFFSET[i]) begin
               rw_q[i] <= (rw_q[i] & ~RW_WMASK[i]) | (shift_q & RW_WMASK[i]); // RULE8
            end
         end
      end
   end

   // ----------------------------------------
   // event flags, set wins over clear
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < W1C_COUNT; i++) begin
            w1c_q[i] <= W1C_RESET;
         end
      end else begin
         for (int i = 0; i < W1C_COUNT; i++) begin
            if (wr_fire && ptr_q == W1C_OFFSET[i]) begin
               w1c_q[i] <= ((w1c_q[i] & ~shift_q) | event_set[8*i +: 8]) & W1C_LIVE[i];
            end else begin
               w1c_q[i] <= (w1c_q[i] | event_set[8*i +: 8]) & W1C_LIVE[i];
            end
         end
      end
   end

   // ----------------------------------------
   // alert pin, low while an enabled flag stands
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         alert_n_q <= 1'b1;
      end else begin
         alert_n_q <= !(|(w1c_q[0] & rw_q[SLOT_ENABLE_LOW]) || |(w1c_q[1] & rw_q[SLOT_ENABLE_HIGH]));
      end
   end

   // ----------------------------------------
   // write-only strobes
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pulse_q <= '0;
      end else begin
         pulse_q.cmd_valid <= wr_fire && (ptr_q == COMMAND_ENTRY);
         pulse_q.txbuf_valid <= wr_fire && (ptr_q == TRANSMIT_MESSAGE_BUFFER);
         if (wr_fire && ptr_q == COMMAND_ENTRY) begin
            pulse_q.cmd_data <= shift_q;
         end
         if (wr_fire && ptr_q == TRANSMIT_MESSAGE_BUFFER) begin
            pulse_q.txbuf_data <= shift_q;
         end
      end
   end

   // open drain: data is always low, enable carries the bit
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sda_out_q <= 1'b0;
      end else begin
         sda_out_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sda_o = sda_out_q;
   assign sda_oe = sda_oe_q;
   assign alert_n = alert_n_q;
   assign write_pulse = pulse_q;
   assign control_out.port_controller_control = rw_q[SLOT_PORT_CONTROL];
   assign control_out.termination_role_control = rw_q[SLOT_ROLE_CONTROL];
   assign control_out.fault_detect_control = rw_q[SLOT_FAULT_CONTROL];
   assign control_out.power_path_control = rw_q[SLOT_POWER_CONTROL];
   assign control_out.converter_setup = converter_setup_t'(rw_q[SLOT_CONVERTER_SETUP]); // RULE8

endmodule
`default_nettype wire

// File: inc/port_map_pkg.sv
// register offsets, field layouts, reset values and carriers for the port controller register map
// assumes a single device clock and one asynchronous power-on reset
package port_map_pkg;

   // ----------------------------------------
   // identification and revision offsets
   // ----------------------------------------
   localparam logic [7:0] VENDOR_CODE_LOW = 8'h00;
   localparam logic [7:0] VENDOR_CODE_HIGH = 8'h01;
   localparam logic [7:0] PRODUCT_CODE_LOW = 8'h02;
   localparam logic [7:0] PRODUCT_CODE_HIGH = 8'h03;
   localparam logic [7:0] RELEASE_CODE_LOW = 8'h04;
   localparam logic [7:0] RELEASE_CODE_HIGH = 8'h05;
   localparam logic [7:0] CONNECTOR_SPEC_REV = 8'h06;
   localparam logic [7:0] DELIVERY_SPEC_VERSION = 8'h08;
   localparam logic [7:0] DELIVERY_SPEC_REVISION = 8'h09;
   localparam logic [7:0] INTERFACE_SPEC_VERSION = 8'h0a;
   localparam logic [7:0] INTERFACE_SPEC_REVISION = 8'h0b;

   // fixed packed-bcd revision values
   localparam logic [7:0] CONNECTOR_SPEC_REV_VAL = 8'h13;
   localparam logic [7:0] DELIVERY_SPEC_VERSION_VAL = 8'h12;
   localparam logic [7:0] DELIVERY_SPEC_REVISION_VAL = 8'h30;
   localparam logic [7:0] INTERFACE_SPEC_VERSION_VAL = 8'h11;
   localparam logic [7:0] INTERFACE_SPEC_REVISION_VAL = 8'h20;

   // ----------------------------------------
   // live status, capabilities and strobes
   // ----------------------------------------
   localparam logic [7:0] CONFIG_LINE_STATE = 8'h1d;
   localparam logic [7:0] POWER_STATE = 8'h1e;
   localparam logic [7:0] EXTENDED_STATE = 8'h20;
   localparam logic [7:0] COMMAND_ENTRY = 8'h23;
   localparam logic [7:0] CAPABILITY_FIRST = 8'h24;
   localparam logic [7:0] CAPABILITY_LAST = 8'h29;
   localparam logic [7:0] RECEIVE_MESSAGE_BUFFER = 8'h30;
   localparam logic [7:0] TRANSMIT_MESSAGE_BUFFER = 8'h51;
   localparam logic [7:0] BUS_VOLTAGE_LOW = 8'h70;
   localparam logic [7:0] BUS_VOLTAGE_HIGH = 8'h71;
   localparam int READING_SCALE_POS = 2;
   localparam int READING_TOP_POS = 0;

   // ----------------------------------------
   // write-one-to-clear event registers
   // ----------------------------------------
   localparam int W1C_COUNT = 4;
   localparam logic [7:0] W1C_OFFSET [W1C_COUNT] = '{8'h10, 8'h11, 8'h1f, 8'h21};
   localparam logic [7:0] W1C_LIVE [W1C_COUNT] = '{8'hff, 8'ha7, 8'hff, 8'h07};
   localparam logic [7:0] W1C_RESET = 8'h00;

   // ----------------------------------------
   // read-write registers, enables first
   // ----------------------------------------
   localparam int RW_COUNT = 21;
   localparam logic [7:0] RW_OFFSET [RW_COUNT] = '{
      8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h2a,
      8'h2e, 8'h2f, 8'h50, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h83};
   localparam logic [7:0] RW_WMASK [RW_COUNT] = '{
      8'hff, 8'hb7, 8'hff, 8'hff, 8'h01, 8'h07, 8'hff, 8'h7f, 8'h1f, 8'hff, 8'h03,
      8'h1f, 8'h7f, 8'h37, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff};
   localparam logic [7:0] RW_RESET [RW_COUNT] = '{
      8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam int SLOT_ENABLE_LOW = 0;
   localparam int SLOT_ENABLE_HIGH = 1;
   localparam int SLOT_PORT_CONTROL = 6;
   localparam int SLOT_ROLE_CONTROL = 7;
   localparam int SLOT_FAULT_CONTROL = 8;
   localparam int SLOT_POWER_CONTROL = 9;
   localparam int SLOT_CONVERTER_SETUP = 20;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] slope_setting;
      logic [1:0] switching_frequency_select;
      logic sync_direction;
      logic [1:0] spread_select;
   } converter_setup_t;

   typedef struct packed {
      logic [7:0] port_controller_control;
      logic [7:0] termination_role_control;
      logic [7:0] fault_detect_control;
      logic [7:0] power_path_control;
      converter_setup_t converter_setup;
   } control_out_t;

   typedef struct packed {
      logic [7:0] config_line_state;
      logic [7:0] power_state;
      logic [7:0] extended_state;
      logic [1:0] reading_scale;
      logic [9:0] bus_voltage_reading;
   } status_in_t;

   typedef struct packed {
      logic cmd_valid;
      logic [7:0] cmd_data;
      logic txbuf_valid;
      logic [7:0] txbuf_data;
   } write_pulse_t;

endpackage

// File: src/i2c_line_watch.sv
// synchronises the serial clock and data pins and reports edges, start and stop
// assumes both pins arrive asynchronously to ref_clk
`timescale 1ns/1ps
`default_nettype none
module i2c_line_watch (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // pins
   input wire logic scl_i,
   input wire logic sda_i,
   // events
   output logic scl_rise,
   output logic scl_fall,
   output logic start_seen,
   output logic stop_seen,
   output logic sda_level
);

   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;

   // ----------------------------------------
   // two-flop synchronisers, then history
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   assign sda_level = sda_sync_q[1];
   assign scl_rise = scl_sync_q[1] && !scl_prev_q;
   assign scl_fall = !scl_sync_q[1] && scl_prev_q;
   // data moving while the clock is high frames a transfer
   assign start_seen = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
   assign stop_seen = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];

endmodule
`default_nettype wire

// File: tb/port_map_properties.sv
// pin-level checks on the register map
// assumes it is bound into port_controller_id_register_map
`timescale 1ns/1ps
`default_nettype none
module port_map_properties
   import port_map_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic buck_boost_strap,
   // power stage side
   input wire status_in_t status_in,
   input wire logic [W1C_COUNT*8-1:0] event_set,
   input wire control_out_t control_out,
   input wire write_pulse_t write_pulse,
   input wire logic alert_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ------------------------------
   // bus steps
   // ------------------------------
   sequence start_cond;
      scl_i && $past(scl_i) && $fell(sda_i);
   endsequence
   sequence low_settled;
      !scl_i && !$past(scl_i, 2);
   endsequence
   // ------------------------------
   // properties
   // ------------------------------
   reset_quiet_a: assert property ($rose(rstn) |-> !sda_oe && alert_n && !write_pulse.cmd_valid)
      else $error("pins not idle after reset");
   open_drain_a: assert property (sda_o == 1'b0)
      else $error("data pin driven high");
   answer_timing_a: assert property ($changed(sda_oe) |-> low_settled)
      else $error("data enable moved outside clock low");
   start_released_a: assert property (start_cond |-> !sda_oe [*8])
      else $error("data held low after start");
   cmd_pulse_a: assert property (write_pulse.cmd_valid |=> !write_pulse.cmd_valid)
      else $error("command strobe longer than one cycle");
   tx_pulse_a: assert property (write_pulse.txbuf_valid |=> !write_pulse.txbuf_valid)
      else $error("transmit strobe longer than one cycle");
   setup_update_a: assert property ($changed(control_out) |-> low_settled)
      else $error("controls moved outside a byte end");
   strobe_timing_a: assert property (write_pulse.cmd_valid || write_pulse.txbuf_valid |-> low_settled)
      else $error("strobe outside a byte end");
endmodule
bind port_controller_id_register_map port_map_properties u_props (
   .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .buck_boost_strap(buck_boost_strap), .status_in(status_in), .event_set(event_set),
   .control_out(control_out), .write_pulse(write_pulse), .alert_n(alert_n));
`default_nettype wire

// File: tb/i2c_host_model.sv
// i2c controller on the far side, driven through tasks
// assumes a pull-up on the data line; 8 ref_clk cycles per bus phase
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
   // clock
   input wire logic ref_clk,
   // device data enable
   input wire logic dev_oe,
   // bus wires
   output wire logic scl,
   output wire logic sda
);
   logic clk_lvl = 1'b1;
   logic drv = 1'b1;
   assign scl = clk_lvl;
   // wired-and with pull-up
   assign sda = drv & ~dev_oe;
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic start_cond;
      drv = 1'b1;
      hold(8);
      clk_lvl = 1'b1;
      hold(8);
      drv = 1'b0;
      hold(8);
      clk_lvl = 1'b0;
      hold(8);
   endtask
   task automatic stop_cond;
      drv = 1'b0;
      hold(8);
      clk_lvl = 1'b1;
      hold(8);
      drv = 1'b1;
      hold(8);
   endtask
   task automatic clk_bit(input logic b, output logic r);
      drv = b;
      hold(8);
      clk_lvl = 1'b1;
      hold(8);
      r = sda;
      clk_lvl = 1'b0;
      hold(8);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ain, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], r);
         q[i] = r;
      end
      clk_bit(ain, r);
      ack = ~r;
   endtask
endmodule
`default_nettype wire

// File: tb/tb_port_controller_id_register_map.sv
// self-checking bench for the register map over i2c
// assumes the host model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_port_controller_id_register_map
   import port_map_pkg::*;
;
   localparam logic [6:0] DEV = 7'h22;
   // arbitrary identification values
   localparam logic [15:0] VEND = 16'h4d21;
   localparam logic [7:0] PBB = 8'h61;
   localparam logic [7:0] PBO = 8'h62;
   localparam logic [7:0] PHI = 8'h5c;
   localparam logic [15:0] REL = 16'h0c33;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic strap = 1'b1;
   status_in_t status_in = '0;
   logic [W1C_COUNT*8-1:0] event_set = '0;
   control_out_t control_out;
   write_pulse_t write_pulse;
   wire logic scl, sda, sda_oe, alert_n;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   int pulses = 0;
   logic [15:0] v;
   logic [7:0] q;
   logic k;
   always #2 ref_clk = ~ref_clk;
   port_controller_id_register_map #(.DEVICE_ADDRESS(DEV), .VENDOR_CODE(VEND), .PRODUCT_LOW_BUCK_BOOST(PBB),
      .PRODUCT_LOW_BUCK_ONLY(PBO), .PRODUCT_HIGH(PHI), .RELEASE_CODE(REL)) uut (
      .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .buck_boost_strap(strap), .status_in(status_in), .event_set(event_set),
      .control_out(control_out), .write_pulse(write_pulse), .alert_n(alert_n));
   i2c_host_model host (.ref_clk(ref_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // strobes are counted mid-cycle, where they have settled
   always @(negedge ref_clk) begin
      cycles++;
      if (write_pulse.cmd_valid === 1'b1 || write_pulse.txbuf_valid === 1'b1)
         pulses++;
      if (cycles == 80000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic k1, k2, k3;
      host.start_cond();
      host.xfer({DEV, 1'b0}, 1'b1, q, k1);
      host.xfer(a, 1'b1, q, k2);
      host.xfer(d, 1'b1, q, k3);
      host.stop_cond();
      chk({13'h0, k1, k2, k3}, 16'h0007);
   endtask
   task automatic rd2(input logic [7:0] a, output logic [15:0] r);
      host.start_cond();
      host.xfer({DEV, 1'b0}, 1'b1, q, k);
      host.xfer(a, 1'b1, q, k);
      host.start_cond();
      host.xfer({DEV, 1'b1}, 1'b1, q, k);
      host.xfer(8'hff, 1'b0, r[7:0], k);
      host.xfer(8'hff, 1'b1, r[15:8], k);
      host.stop_cond();
   endtask
   task automatic ids(input logic [7:0] plo);
      logic [7:0] ta [7];
      logic [15:0] tv [7];
      ta = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h70};
      tv = '{VEND, {PHI, plo}, REL, 16'h0013, 16'h3012, 16'h2011, 16'h0ad5};
      for (int i = 0; i < 7; i++) begin
         rd2(ta[i], v);
         chk(v, tv[i]);
      end
   endtask
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      status_in.reading_scale = 2'b10;
      status_in.bus_voltage_reading = 10'h2d5;
      host.hold(2);
      rstn = 1'b1;
      host.hold(8);
      chk({15'h0, alert_n}, 16'h0001);
      ids(PBB);
      $display("identification read test done");
      for (int a = 0; a < 12; a++)
         wr(8'(a), 8'ha5);
      ids(PBB);
      $display("identification write test done");
      wr(8'h83, 8'hb5);
      chk({8'h0, control_out.converter_setup}, {8'h0, 3'b101, 2'b10, 1'b1, 2'b01});
      rd2(8'h83, v);
      chk(v, 16'h00b5);
      wr(8'h23, 8'h3c);
      wr(8'h51, 8'h99);
      chk({write_pulse.cmd_data, write_pulse.txbuf_data}, 16'h3c99);
      chk(16'(pulses), 16'h0002);
      rd2(8'h22, v);
      chk(v, 16'h0000);
      $display("setup and strobe test done");
      status_in.config_line_state = 8'h3c;
      status_in.power_state = 8'hc3;
      event_set[1] = 1'b1;
      host.hold(1);
      event_set[1] = 1'b0;
      host.hold(4);
      chk({15'h0, alert_n}, 16'h0000);
      rd2(8'h10, v);
      chk(v, 16'h0002);
      wr(8'h10, 8'h02);
      rd2(8'h10, v);
      chk(v, 16'h0000);
      chk({15'h0, alert_n}, 16'h0001);
      rd2(8'h1d, v);
      chk(v, 16'hc33c);
      $display("event and status test done");
      host.start_cond();
      host.xfer({7'h23, 1'b0}, 1'b1, q, k);
      host.stop_cond();
      chk({15'h0, k}, 16'h0000);
      $display("foreign address test done");
      rstn = 1'b0;
      strap = 1'b0;
      host.hold(2);
      chk({8'h0, control_out.converter_setup}, 16'h0000);
      rstn = 1'b1;
      host.hold(8);
      ids(PBO);
      $display("second reset test done");
      end_of_test();
   end
endmodule
`default_nettype wire
